// File: inc/remap_map.svh
// Register indices, field positions and reset values of the remap block.
// Assumes byte address = index * 4 on a 32-bit AXI4-Lite bus.
`ifndef REMAP_MAP_SVH
`define REMAP_MAP_SVH
`define TARGET_BASE_IDX 10'h074
`define TARGET5_IDX     10'h074
`define TARGET6_IDX     10'h075
`define TARGET7_IDX     10'h076
`define ALIAS_BASE_IDX  10'h07B
`define ALIAS5_IDX      10'h07B
`define ALIAS6_IDX      10'h07C
`define ALIAS7_IDX      10'h07D
`define STATUS_IDX      10'h07E
`define ENTRY_RESET     7'h00
`define ADDR_MSB        7
`define ADDR_LSB        1
`define FIELD_ZERO      7'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define WORD_LSB        2
`define FIRST_TARGET    5
`endif

// File: inc/remap_pkg.sv
// Types shared by the remote target remap block.
// Assumes nothing beyond a SystemVerilog compiler.
package remap_pkg;
  typedef struct packed {
    logic [6:0] addr;
    logic       rnw;
  } i2c_req_type;

  typedef enum logic [1:0] {
    RES_NONE     = 2'b00,
    RES_FORWARD  = 2'b01,
    RES_DISABLED = 2'b10,
    RES_NO_MATCH = 2'b11
  } result_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_FORWARD = 2'b01,
    ST_DONE    = 2'b10
  } state_type;
endpackage : remap_pkg

// File: hdl/remap_axil_slave.sv
// AXI4-Lite slave front end turning bus transfers into register strobes.
// Assumes the parent decodes the word index and answers hits combinationally.
`timescale 1ns/100ps
`default_nettype none
`include "remap_map.svh"
module remap_axil_slave #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write channels
  input  wire logic                  awvalid,
  output var  logic                  awready,
  input  wire logic [ADDR_WIDTH-1:0] awaddr,
  input  wire logic                  wvalid,
  output var  logic                  wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output var  logic                  bvalid,
  input  wire logic                  bready,
  output var  logic [1:0]            bresp,
  // Read channels
  input  wire logic                  arvalid,
  output var  logic                  arready,
  input  wire logic [ADDR_WIDTH-1:0] araddr,
  output var  logic                  rvalid,
  input  wire logic                  rready,
  output var  logic [31:0]           rdata,
  output var  logic [1:0]            rresp,
  // Register side
  output var  logic                  wr_en,
  output var  logic [9:0]            wr_index,
  output var  logic [7:0]            wr_data,
  output var  logic                  wr_lane0,
  input  wire logic                  wr_hit,
  output var  logic [9:0]            rd_index,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_hit
);
  if (ADDR_WIDTH < 12) begin : g_width_check
    $error("ADDR_WIDTH must be at least 12");
  end

  logic [9:0] aw_index;
  logic [9:0] ar_index;
  logic       rd_fire;

  // A write fires once both address and data are held
  assign wr_en    = !awready && !wready && !bvalid;
  assign wr_index = aw_index;
  assign rd_index = ar_index;
  assign rd_fire  = !arready && !rvalid;

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
      aw_index <= 10'h000;
      wr_data  <= 8'h00;
      wr_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready  <= 1'b0;
        aw_index <= awaddr[`WORD_LSB +: 10];
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        wr_data  <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read answered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h00000000;
      rresp    <= `RESP_OKAY;
      ar_index <= 10'h000;
    end else begin
      if (arvalid && arready) begin
        arready  <= 1'b0;
        ar_index <= araddr[`WORD_LSB +: 10];
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata  <= rd_hit ? rd_data : 32'h00000000;
        rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : remap_axil_slave
`default_nettype wire

// File: hdl/remap_alias_match.sv
// Alias comparator: finds the entry whose alias equals the incoming address.
// Assumes alias and target tables are held stable by the parent.
`timescale 1ns/100ps
`default_nettype none
`include "remap_map.svh"
module remap_alias_match #(
  parameter int ENTRIES = 3
) (
  // Tables
  input  wire logic [ENTRIES-1:0][6:0] alias_table,
  input  wire logic [ENTRIES-1:0][6:0] target_table,
  // Lookup
  input  wire logic [6:0]              addr,
  output var  logic                    hit,
  output var  logic [1:0]              index,
  output var  logic                    disabled,
  output var  logic [6:0]              mapped
);
  if (ENTRIES < 1 || ENTRIES > 4) begin : g_entries_check
    $error("ENTRIES must be 1 to 4");
  end

  // Each entry compared on its own; lowest index wins on a duplicate
  always_comb begin
    hit      = 1'b0;
    index    = 2'h0;
    disabled = 1'b0;
    mapped   = addr;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (alias_table[i] != `FIELD_ZERO && alias_table[i] == addr) begin
        hit      = 1'b1;
        index    = 2'(i);
        disabled = (target_table[i] == `FIELD_ZERO);
        mapped   = target_table[i];
      end
    end
  end
endmodule : remap_alias_match
`default_nettype wire

// File: hdl/remap_target_bridge.sv
// Remote target remap for entries 5 to 7: register file, lookup and forwarding.
// Assumes a local I2C front end that presents decoded address bytes and a
// control channel sender that takes remapped requests by valid and ready.
`timescale 1ns/100ps
`default_nettype none
`include "remap_map.svh"
module remap_target_bridge #(
  parameter int ADDR_WIDTH = 12,
  parameter int ENTRIES    = 3
) (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write channels
  input  wire logic                     awvalid,
  output var  logic                     awready,
  input  wire logic [ADDR_WIDTH-1:0]    awaddr,
  input  wire logic                     wvalid,
  output var  logic                     wready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  output var  logic                     bvalid,
  input  wire logic                     bready,
  output var  logic [1:0]               bresp,
  // AXI4-Lite read channels
  input  wire logic                     arvalid,
  output var  logic                     arready,
  input  wire logic [ADDR_WIDTH-1:0]    araddr,
  output var  logic                     rvalid,
  input  wire logic                     rready,
  output var  logic [31:0]              rdata,
  output var  logic [1:0]               rresp,
  // Local I2C requests
  input  wire logic                     req_valid,
  output var  logic                     req_ready,
  input  wire remap_pkg::i2c_req_type   req,
  // Requests toward the control channel
  output var  logic                     fwd_valid,
  input  wire logic                     fwd_ready,
  output var  remap_pkg::i2c_req_type   fwd,
  // Outcome of each request
  output var  logic                     done_valid,
  output var  remap_pkg::result_type    done_result,
  output var  logic [1:0]               done_index
);
  import remap_pkg::*;

  if (ENTRIES != 3) begin : g_entries_check
    $error("ENTRIES must be 3 for this register map");
  end

  logic [ENTRIES-1:0][6:0] target_addr;
  logic [ENTRIES-1:0][6:0] alias_addr;
  logic                    wr_en;
  logic [9:0]              wr_index;
  logic [7:0]              wr_data;
  logic                    wr_lane0;
  logic [9:0]              rd_index;
  logic [31:0]             rd_data;
  logic                    wr_hit;
  logic                    rd_hit;
  logic                    match_hit;
  logic [1:0]              match_index;
  logic                    match_disabled;
  logic [6:0]              match_addr;
  state_type               state;
  state_type               next_state;
  result_type              last_result;
  logic [1:0]              last_index;
  logic                    take;

  // Bus front end
  remap_axil_slave #(
    .ADDR_WIDTH (ADDR_WIDTH)
  ) u_slave (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awvalid  (awvalid),
    .awready  (awready),
    .awaddr   (awaddr),
    .wvalid   (wvalid),
    .wready   (wready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .bvalid   (bvalid),
    .bready   (bready),
    .bresp    (bresp),
    .arvalid  (arvalid),
    .arready  (arready),
    .araddr   (araddr),
    .rvalid   (rvalid),
    .rready   (rready),
    .rdata    (rdata),
    .rresp    (rresp),
    .wr_en    (wr_en),
    .wr_index (wr_index),
    .wr_data  (wr_data),
    .wr_lane0 (wr_lane0),
    .wr_hit   (wr_hit),
    .rd_index (rd_index),
    .rd_data  (rd_data),
    .rd_hit   (rd_hit)
  );

  // Entry number of an index within a table, or none
  function automatic logic [2:0] entry_of(input logic [9:0] idx, input logic [9:0] base);
    logic [9:0] off;
    off = idx - base;
    entry_of = (idx >= base && off < 10'(ENTRIES)) ? {1'b1, off[1:0]} : 3'b000;
  endfunction : entry_of

  // Address decode for writes and reads
  wire [2:0] wr_tgt = entry_of(wr_index, `TARGET_BASE_IDX);
  wire [2:0] wr_als = entry_of(wr_index, `ALIAS_BASE_IDX);
  wire [2:0] rd_tgt = entry_of(rd_index, `TARGET_BASE_IDX);
  wire [2:0] rd_als = entry_of(rd_index, `ALIAS_BASE_IDX);
  wire       rd_sts = (rd_index == `STATUS_IDX);
  assign wr_hit = wr_tgt[2] || wr_als[2] || (wr_index == `STATUS_IDX);
  assign rd_hit = rd_tgt[2] || rd_als[2] || rd_sts;

  // Read mux; bit 0 of every entry reads as zero
  wire [6:0] rd_field = rd_tgt[2] ? target_addr[rd_tgt[1:0]] :
                        rd_als[2] ? alias_addr[rd_als[1:0]] : `FIELD_ZERO;
  wire [7:0] status_byte = {3'h0, state == ST_IDLE, last_index, last_result};
  assign rd_data = rd_sts ? {24'h000000, status_byte}
                          : {24'h000000, rd_field, 1'b0};

  // Entry registers, written only through byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_addr <= {ENTRIES{`ENTRY_RESET}};
      alias_addr  <= {ENTRIES{`ENTRY_RESET}};
    end else if (wr_en && wr_lane0) begin
      if (wr_tgt[2]) begin
        target_addr[wr_tgt[1:0]] <= wr_data[`ADDR_MSB:`ADDR_LSB];
      end
      if (wr_als[2]) begin
        alias_addr[wr_als[1:0]] <= wr_data[`ADDR_MSB:`ADDR_LSB];
      end
    end
  end

  // Alias lookup
  remap_alias_match #(
    .ENTRIES (ENTRIES)
  ) u_match (
    .alias_table  (alias_addr),
    .target_table (target_addr),
    .addr         (req.addr),
    .hit          (match_hit),
    .index        (match_index),
    .disabled     (match_disabled),
    .mapped       (match_addr)
  );

  // Request sequencing
  assign take = req_valid && req_ready;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take) next_state = (match_hit && !match_disabled) ? ST_FORWARD : ST_DONE;
      end
      ST_FORWARD: begin
        if (fwd_ready) next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      req_ready   <= 1'b1;
      fwd_valid   <= 1'b0;
      fwd         <= '0;
      done_valid  <= 1'b0;
      done_result <= RES_NONE;
      done_index  <= 2'h0;
      last_result <= RES_NONE;
      last_index  <= 2'h0;
    end else begin
      state      <= next_state;
      req_ready  <= (next_state == ST_IDLE);
      done_valid <= (state == ST_FORWARD && fwd_ready) || (take && next_state == ST_DONE);
      if (take) begin
        fwd         <= '{addr: match_addr, rnw: req.rnw};
        fwd_valid   <= match_hit && !match_disabled;
        done_index  <= match_index;
        done_result <= !match_hit ? RES_NO_MATCH :
                       match_disabled ? RES_DISABLED : RES_FORWARD;
        last_index  <= match_index;
        last_result <= !match_hit ? RES_NO_MATCH :
                       match_disabled ? RES_DISABLED : RES_FORWARD;
      end else if (fwd_valid && fwd_ready) begin
        fwd_valid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [6:0] seen_target;
  assign seen_target = target_addr[match_index];

  reg_store_a: assert property (
    wr_en && wr_lane0 && wr_tgt[2] |=> target_addr[$past(wr_tgt[1:0])] == $past(wr_data[7:1]))
    else $error("target entry not stored from bits 7:1");
  remap_swap_a: assert property (
    take && match_hit && !match_disabled |=> fwd_valid && fwd.addr == $past(seen_target))
    else $error("forwarded address is not the stored target");
  order_fwd_a: assert property (
    fwd_valid |-> fwd.addr != `FIELD_ZERO && state == ST_FORWARD)
    else $error("forward without a nonzero substituted address");
  zero_block_a: assert property (
    take && match_disabled |=> !fwd_valid ##1 !fwd_valid)
    else $error("request forwarded for a zero target entry");
  entry_indep_a: assert property (
    take && match_hit |-> alias_addr[match_index] == req.addr)
    else $error("matched entry does not own the alias");
  alias_zero_a: assert property (
    take && req.addr == `FIELD_ZERO |=> done_valid && done_result == RES_NO_MATCH)
    else $error("zero alias address matched an entry");
  rsvd_bit_a: assert property (
    rvalid && !rd_sts |-> rdata[0] == 1'b0)
    else $error("reserved bit reads nonzero");
  fwd_hold_a: assert property (
    fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd))
    else $error("forward request dropped before it was taken");

  // Request sequencing and outcome
  done_pulse_a: assert property (
    done_valid |=> !done_valid)
    else $error("outcome strobe longer than one cycle");
  req_gate_a: assert property (
    req_ready == (state == ST_IDLE))
    else $error("request accepted outside idle");
  fwd_end_a: assert property (
    fwd_valid && fwd_ready |=> !fwd_valid && done_valid && done_result == RES_FORWARD)
    else $error("forward handshake not closed by a forward outcome");
  done_fwd_a: assert property (
    done_valid && done_result == RES_FORWARD |-> $past(fwd_valid) && $past(fwd_ready))
    else $error("forward outcome without a channel handshake");
  nomatch_done_a: assert property (
    take && !match_hit |=> done_valid && !fwd_valid && done_result == RES_NO_MATCH)
    else $error("unmatched address not reported as such");
  disabled_index_a: assert property (
    take && match_hit && match_disabled |=>
      done_valid && done_result == RES_DISABLED && done_index == $past(match_index))
    else $error("disabled entry outcome wrong");
  fwd_index_a: assert property (
    take && match_hit && !match_disabled |=>
      done_index == $past(match_index) && fwd.rnw == $past(req.rnw))
    else $error("forward carries wrong index or direction");
  done_idle_a: assert property (
    state == ST_DONE |=> state == ST_IDLE && req_ready)
    else $error("sequencer stuck after outcome");

  // Entry stores
  alias_store_a: assert property (
    wr_en && wr_lane0 && wr_als[2] |=>
      alias_addr[$past(wr_als[1:0])] == $past(wr_data[`ADDR_MSB:`ADDR_LSB]))
    else $error("alias entry not stored from bits 7:1");
  lane_skip_a: assert property (
    wr_en && !wr_lane0 |=> $stable(target_addr) && $stable(alias_addr))
    else $error("entry changed by a write without byte lane 0");
  target_only_a: assert property (
    wr_en && wr_tgt[2] |=> $stable(alias_addr))
    else $error("target write disturbed an alias entry");
  alias_only_a: assert property (
    wr_en && wr_als[2] |=> $stable(target_addr))
    else $error("alias write disturbed a target entry");

  // Register bus answers
  bad_write_a: assert property (
    wr_en && !wr_hit |=>
      bvalid && bresp == `RESP_SLVERR && $stable(target_addr) && $stable(alias_addr))
    else $error("unmapped write not refused");
  bad_read_a: assert property (
    rvalid && !rd_hit |-> rresp == `RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");
  read_target_a: assert property (
    rvalid && rd_tgt[2] |-> rresp == `RESP_OKAY && rdata[31:8] == 24'h000000)
    else $error("target entry read with bad response or upper bits");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
  rdata_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before it was taken");

  fwd_done_c: cover property (take && match_hit && !match_disabled ##[1:20] done_valid);
  disabled_c: cover property (take && match_disabled);
  nomatch_c:  cover property (take && !match_hit);
  stall_c:    cover property (fwd_valid && !fwd_ready ##1 fwd_valid && fwd_ready);
  slverr_c:   cover property (bvalid && bresp == `RESP_SLVERR);
endmodule : remap_target_bridge
`default_nettype wire

// File: verification/remap_far_end.sv
// Far end model: the control channel sender that takes remapped requests.
// Assumes the bridge holds fwd_valid and fwd until fwd_ready is sampled high.
`timescale 1ns/100ps
`default_nettype none
module remap_far_end (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pace control from the bench
  input  wire logic slow,
  // Channel handshake
  input  wire logic fwd_valid,
  output var  logic fwd_ready
);
  logic [1:0] wait_count;

  // Prompt mode takes at once; slow mode stalls a request for three cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_count <= 2'h0;
      fwd_ready  <= 1'b0;
    end else begin
      wait_count <= fwd_valid ? wait_count + 2'h1 : 2'h0;
      fwd_ready  <= slow ? (fwd_valid && wait_count == 2'h2) : 1'b1;
    end
  end
endmodule : remap_far_end
`default_nettype wire

// File: verification/remap_target_bridge_bench.sv
// Self-checking bench for the remote target remap bridge.
// Assumes the far end model remap_far_end and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "remap_map.svh"
module remap_target_bridge_bench;
  import remap_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, req_valid = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, req_ready, fwd_valid, fwd_ready;
  logic        done_valid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, done_index;
  i2c_req_type req = '0, fwd;
  result_type  done_result;
  int          fails = 0, checks_done = 0, tgt [3] = '{0, 0, 0}, als [3] = '{0, 0, 0};

  remap_target_bridge DUT (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .req_valid, .req_ready, .req, .fwd_valid, .fwd_ready, .fwd, .done_valid,
    .done_result, .done_index
  );
  remap_far_end far_end (.aclk, .aresetn, .slow, .fwd_valid, .fwd_ready);

  // Free running clock
  always #5 aclk = ~aclk;

  task automatic end_of_test;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_up;
    fails++;
    $display("mismatch at %0t: wait timed out", $time);
    end_of_test();
  endtask : give_up

  // Byte address of a target (kind 0) or alias (kind 1) entry
  function automatic logic [11:0] reg_addr(input int kind, input int i);
    reg_addr = {10'((kind != 0 ? `ALIAS_BASE_IDX : `TARGET_BASE_IDX) + i), 2'b00};
  endfunction : reg_addr

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) give_up();
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) give_up();
  endtask : axi_read

  // Writes an entry with random upper bits, updates the model, reads it back
  task automatic reg_write(input int kind, input int i, input logic [7:0] v);
    logic [1:0]  r;
    logic [31:0] d;
    d = $urandom();
    d[7:0] = v;
    axi_write(reg_addr(kind, i), d, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY});
    if (kind == 0) tgt[i] = int'(v[7:1]);
    else als[i] = int'(v[7:1]);
    axi_read(reg_addr(kind, i), d, r);
    check(d, {24'h0, v[7:1], 1'b0});
  endtask : reg_write

  // Sends one address byte and compares the outcome with the model lookup
  task automatic send_req(input logic [6:0] a, input logic rnw);
    int n, i, e_res, e_idx, e_map, seen;
    e_res = 3;
    e_idx = 0;
    e_map = 0;
    seen = 0;
    for (i = 2; i >= 0; i--) begin
      if (als[i] != 0 && als[i] == int'(a)) begin
        e_idx = i;
        e_map = tgt[i];
        e_res = tgt[i] == 0 ? 2 : 1;
      end
    end
    @(posedge aclk);
    req       <= '{addr: a, rnw: rnw};
    req_valid <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (req_valid && req_ready) req_valid <= 1'b0;
      if (fwd_valid && fwd_ready) begin
        seen++;
        check({24'h0, fwd}, {24'h0, 7'(e_map), rnw});
      end
      if (done_valid) break;
    end
    if (n == 60) give_up();
    check(32'(seen), 32'(e_res == 1));
    check({30'h0, done_result}, 32'(e_res));
    if (e_res != 3) check({30'h0, done_index}, 32'(e_idx));
  endtask : send_req

  // Main sequence
  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    int          i, k;
    void'($urandom(32'h92ECE678));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset value of every entry
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 3; i++) begin
        axi_read(reg_addr(k, i), d, r);
        check(d, 32'h0);
      end
    end
    // Unmapped place is refused and stores nothing
    axi_write(12'h000, 32'hFFFF_FFFF, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_read(12'h000, d, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR});
    check(d, 32'h0);
    // A write without byte lane 0 keeps the entry
    wstrb <= 4'hE;
    axi_write(reg_addr(0, 0), 32'h0000_00FE, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY});
    wstrb <= 4'hF;
    axi_read(reg_addr(0, 0), d, r);
    check(d, 32'h0);
    // Distinct aliases, random targets with bit 0 set
    for (i = 0; i < 3; i++) begin
      reg_write(0, i, 8'($urandom()) | 8'h03);
      reg_write(1, i, {7'(7'h20 + i), 1'b1});
    end
    // Each alias reaches its own target, promptly then with a stalling far end
    for (k = 0; k < 2; k++) begin
      slow <= k[0];
      for (i = 0; i < 3; i++) send_req(7'(als[i]), 1'(i));
    end
    // Zero target blocks its index; zero alias never matches
    reg_write(0, 1, 8'h01);
    send_req(7'(als[1]), 1'b0);
    // Status shows idle, index 1 and the disabled outcome
    axi_read({`STATUS_IDX, 2'b00}, d, r);
    check(d, {27'h0, 1'h1, 2'h1, 2'h2});
    send_req(7'(als[0]), 1'b1);
    reg_write(1, 2, 8'h00);
    send_req(7'h00, 1'b0);
    send_req(7'h22, 1'b1);
    // Random rewrites and requests, duplicates included
    for (k = 0; k < 30; k++) begin
      if (k % 3 == 0) reg_write($urandom_range(1, 0), $urandom_range(2, 0), 8'($urandom()));
      slow <= 1'($urandom());
      if (k[0]) send_req(7'(als[$urandom_range(2, 0)]), 1'($urandom()));
      else send_req(7'($urandom()), 1'($urandom()));
    end
    end_of_test();
  end
endmodule : remap_target_bridge_bench
`default_nettype wire
